// >>> design/acsp_control_port.sv
// Purpose: Two-wire slave control port with run-control and format regs
// Assumes: Bus clock pin also clocks the bit sampler; 200 MHz system clock
// Notes:   Rules carried by this port are listed below
`timescale 1ns/1ps
`default_nettype none
`include "acsp_map.svh"

module acsp_control_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addrStrapLow,
    input wire logic addrStrapHigh,
    input wire logic softReset,
    output logic [6:0] slaveAddr,
    output logic busBusy,
    output logic [1:0] runMode,
    output logic coefApply,
    output logic [3:0] masterSclSel,
    output logic [10:0] masterSclPeriodCycles,
    output logic outFloat,
    output logic inFloat,
    output logic serialOutEn,
    output logic [4:0] frameChannelCount,
    output logic [5:0] wordBits,
    output logic tdmEnable,
    output logic [2:0] frameFormat,
    output logic pcmVariantA,
    output logic pcmVariantB,
    output logic [15:0] leftSlotEnables,
    output logic [15:0] rightSlotEnables
);

    // Bit sampler in the bus clock domain
    logic bitToggle;
    logic bitValue;

    acsp_link_sampler u_sampler (
        .sclClk(sclClk),
        .rst_n(rst_n),
        .sdaIn(sdaIn),
        .bitToggle(bitToggle),
        .bitValue(bitValue)
    );

    // Synchronisers: pins and the toggle pass two flops
    logic sclMeta;
    logic sclSync;
    logic sclPrev;
    logic sdaMeta;
    logic sdaSync;
    logic sdaPrev;
    logic togMeta;
    logic togSync;
    logic togPrev;
    logic [1:0] strapMeta;
    logic [1:0] strapSync;

    always_ff @(posedge clk) begin
        sclMeta <= sclClk;
        sclSync <= sclMeta;
        sdaMeta <= sdaIn;
        sdaSync <= sdaMeta;
        togMeta <= bitToggle;
        togSync <= togMeta;
        strapMeta <= {addrStrapHigh, addrStrapLow};
        strapSync <= strapMeta;
    end

    // Edge history for condition detection
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sclPrev <= 1'b1;
            sdaPrev <= 1'b1;
            togPrev <= 1'b0;
        end else begin
            sclPrev <= sclSync;
            sdaPrev <= sdaSync;
            togPrev <= togSync;
        end
    end

    // Bus events; the sampled bit is stable long before its toggle lands
    wire startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
    wire stopSeen = sclSync & sclPrev & ~sdaPrev & sdaSync;
    wire bitEvent = togSync ^ togPrev;
    wire sclFall = sclPrev & ~sclSync;
    wire rxBit = bitValue;

    // Strap capture: armed by any reset, taken once synchronised
    logic strapArmed;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strapArmed <= 1'b1;
            slaveAddr <= `ACSP_DEV_BASE;
        end else if (softReset) begin
            strapArmed <= 1'b1;
        end else if (strapArmed) begin
            strapArmed <= 1'b0;
            slaveAddr <= `ACSP_DEV_BASE + {5'h00, strapSync};
        end
    end

    // Protocol state
    acsp_pkg::acsp_state_t state;
    acsp_pkg::acsp_kind_t kind;
    logic [3:0] bitCnt;
    logic [7:0] rxShift;
    logic [7:0] txShift;
    logic [7:0] regAddr;
    logic [1:0] byteIdx;
    logic [23:0] wrHold;
    logic readDir;
    logic ackOn;
    logic gotAck;

    // Registers
    logic [31:0] runReg;
    logic [31:0] fmtReg;
    logic [31:0] slotReg;

    // Byte assembly and select decode
    wire [7:0] rxByte = {rxShift[6:0], rxBit};
    wire selMatch = rxByte[7:1] == slaveAddr;
    wire lastRxBit = bitCnt == 4'h7;

    // Register read mux; unmapped offsets read zero
    wire hitRun = regAddr == `ACSP_OFF_RUN;
    wire hitFmt = regAddr == `ACSP_OFF_FMT;
    wire hitSlot = regAddr == `ACSP_OFF_SLOT;
    wire [31:0] readWord = hitRun ? runReg : hitFmt ? fmtReg :
                           hitSlot ? slotReg : 32'h0000_0000;
    wire [4:0] byteShift = {~byteIdx, 3'h0};
    wire [31:0] readShifted = readWord >> byteShift;
    wire [7:0] readByte = readShifted[7:0];
    wire [7:0] nextAddr = regAddr + `ACSP_OFF_STEP;

    // Word commit after the fourth data byte
    wire [31:0] wrWord = {wrHold, rxByte};
    wire commit = (state == acsp_pkg::ST_RECV) && bitEvent && lastRxBit &&
                  (kind == acsp_pkg::KD_DATA) && (byteIdx == 2'h3);
    wire [1:0] newMode = wrWord[`ACSP_RUN_MODE_LSB +: 2];
    wire [1:0] oldMode = runReg[`ACSP_RUN_MODE_LSB +: 2];
    wire oldInactive = oldMode != acsp_pkg::RM_ACTIVE;
    wire goActive = commit && hitRun && oldInactive &&
                    (newMode == acsp_pkg::RM_ACTIVE);

    // Register file; writes only through the bus
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runReg <= `ACSP_RST_RUN;
            fmtReg <= `ACSP_RST_FMT;
            slotReg <= `ACSP_RST_SLOT;
        end else if (commit) begin
            if (hitRun) begin
                runReg <= wrWord & `ACSP_MSK_RUN;
            end
            if (hitFmt) begin
                fmtReg <= wrWord & `ACSP_MSK_FMT;
            end
            if (hitSlot) begin
                slotReg <= wrWord & `ACSP_MSK_SLOT;
            end
        end
    end

    // Open drain: only a low is ever driven; the clock pin is input only
    always_ff @(posedge clk) begin
        sdaOut <= 1'b0;
    end

    // Slave protocol engine; start and stop override every state
    always_ff @(posedge clk) begin
        if (!rst_n || softReset) begin
            state <= acsp_pkg::ST_IDLE;
            kind <= acsp_pkg::KD_SEL;
            bitCnt <= 4'h0;
            rxShift <= 8'h00;
            txShift <= 8'h00;
            regAddr <= 8'h00;
            byteIdx <= 2'h0;
            wrHold <= 24'h00_0000;
            readDir <= 1'b0;
            ackOn <= 1'b0;
            gotAck <= 1'b0;
            sdaOe <= 1'b0;
        end else if (stopSeen) begin
            state <= acsp_pkg::ST_IDLE;
            sdaOe <= 1'b0;
        end else if (startSeen) begin
            state <= acsp_pkg::ST_RECV;
            kind <= acsp_pkg::KD_SEL;
            bitCnt <= 4'h0;
            sdaOe <= 1'b0;
        end else begin
            unique case (state)
                acsp_pkg::ST_IDLE: sdaOe <= 1'b0;
                acsp_pkg::ST_RECV: begin
                    if (bitEvent) begin
                        rxShift <= rxByte;
                        bitCnt <= bitCnt + 4'h1;
                        if (lastRxBit) begin
                            bitCnt <= 4'h0;
                            ackOn <= 1'b0;
                            state <= acsp_pkg::ST_ACK;
                            unique case (kind)
                                acsp_pkg::KD_SEL: begin
                                    readDir <= rxByte[0];
                                    if (!selMatch) begin
                                        state <= acsp_pkg::ST_IDLE;
                                    end
                                end
                                acsp_pkg::KD_REG: begin
                                    regAddr <= rxByte;
                                    byteIdx <= 2'h0;
                                end
                                acsp_pkg::KD_DATA: begin
                                    wrHold <= {wrHold[15:0], rxByte};
                                    byteIdx <= byteIdx + 2'h1;
                                    if (byteIdx == 2'h3) begin
                                        regAddr <= nextAddr;
                                    end
                                end
                            endcase
                        end
                    end
                end
                acsp_pkg::ST_ACK: begin
                    // First fall pulls ack low, second fall releases it
                    if (sclFall && !ackOn) begin
                        ackOn <= 1'b1;
                        sdaOe <= 1'b1;
                    end else if (sclFall) begin
                        sdaOe <= 1'b0;
                        if (kind == acsp_pkg::KD_SEL && readDir) begin
                            sdaOe <= ~readByte[7];
                            txShift <= {readByte[6:0], 1'b0};
                            bitCnt <= 4'h1;
                            state <= acsp_pkg::ST_SEND;
                        end else begin
                            state <= acsp_pkg::ST_RECV;
                            if (kind == acsp_pkg::KD_SEL) begin
                                kind <= acsp_pkg::KD_REG;
                            end else begin
                                kind <= acsp_pkg::KD_DATA;
                            end
                        end
                    end
                end
                acsp_pkg::ST_SEND: begin
                    // Data changes only while SCL is low
                    if (sclFall) begin
                        if (bitCnt == 4'h8) begin
                            sdaOe <= 1'b0;
                            gotAck <= 1'b0;
                            state <= acsp_pkg::ST_MACK;
                            byteIdx <= byteIdx + 2'h1;
                            if (byteIdx == 2'h3) begin
                                regAddr <= nextAddr;
                            end
                        end else begin
                            sdaOe <= ~txShift[7];
                            txShift <= {txShift[6:0], 1'b0};
                            bitCnt <= bitCnt + 4'h1;
                        end
                    end
                end
                acsp_pkg::ST_MACK: begin
                    // A master nack ends the read; it then sends a stop
                    if (bitEvent) begin
                        gotAck <= ~rxBit;
                    end else if (sclFall && gotAck) begin
                        sdaOe <= ~readByte[7];
                        txShift <= {readByte[6:0], 1'b0};
                        bitCnt <= 4'h1;
                        state <= acsp_pkg::ST_SEND;
                    end else if (sclFall) begin
                        state <= acsp_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state <= acsp_pkg::ST_IDLE;
                    sdaOe <= 1'b0;
                end
            endcase
        end
    end

    // Decoded configuration, registered so every output is a flop
    wire [3:0] mSel = runReg[`ACSP_MSCL_LSB +: 4];
    wire [10:0] mSelPlus = {7'h00, mSel} + 11'h002;
    wire [21:0] mPeriodNs = mSelPlus * 11'(`ACSP_MUNIT_MUL);
    wire [21:0] mPeriodCyc = mPeriodNs / 22'(`ACSP_CLK_NS);
    wire [1:0] wlen = fmtReg[`ACSP_WLEN_LSB +: 2];
    wire [2:0] ffmt = fmtReg[`ACSP_FRAME_LSB +: 3];
    wire [5:0] wlenBits = (wlen == 2'h0) ? 6'h10 :
                          (wlen == 2'h1) ? 6'h18 : 6'h20;
    wire isVariantB = ffmt > 3'h3;
    wire [4:0] chanCount = {1'b0, fmtReg[`ACSP_CHN_LSB +: 4]} + 5'h01;
    wire [2:0] ffmtOut = isVariantB ? 3'h4 : ffmt;
    wire busIdle = state == acsp_pkg::ST_IDLE;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            runMode <= acsp_pkg::RM_ACTIVE;
            coefApply <= 1'b0;
            masterSclSel <= 4'h3;
            masterSclPeriodCycles <= 11'h000;
            outFloat <= 1'b0;
            inFloat <= 1'b0;
            serialOutEn <= 1'b1;
            frameChannelCount <= 5'h01;
            wordBits <= 6'h20;
            tdmEnable <= 1'b1;
            frameFormat <= 3'h0;
            pcmVariantA <= 1'b0;
            pcmVariantB <= 1'b0;
            leftSlotEnables <= 16'h0001;
            rightSlotEnables <= 16'h0001;
            busBusy <= 1'b0;
        end else begin
            runMode <= oldMode;
            coefApply <= goActive;
            masterSclSel <= mSel;
            masterSclPeriodCycles <= mPeriodCyc[10:0];
            outFloat <= runReg[`ACSP_OUT_FLOAT_BIT];
            inFloat <= runReg[`ACSP_IN_FLOAT_BIT];
            serialOutEn <= runReg[`ACSP_SEND_EN_BIT];
            frameChannelCount <= chanCount;
            wordBits <= wlenBits;
            tdmEnable <= fmtReg[`ACSP_TDM_BIT];
            frameFormat <= ffmtOut;
            pcmVariantA <= ffmt == 3'h3;
            pcmVariantB <= isVariantB;
            leftSlotEnables <= slotReg[`ACSP_LSLOT_LSB +: 16];
            rightSlotEnables <= slotReg[`ACSP_RSLOT_LSB +: 16];
            busBusy <= ~busIdle;
        end
    end

endmodule

`default_nettype wire

// >>> design/acsp_link_sampler.sv
// Purpose: Samples the data pin on each rising bus clock edge
// Assumes: Bus clock may stop between frames
// Notes:   Each rising edge toggles a flag; the value holds until the next rising edge
`timescale 1ns/1ps
`default_nettype none

module acsp_link_sampler (
    input wire logic sclClk,
    input wire logic rst_n,
    input wire logic sdaIn,
    output logic bitToggle,
    output logic bitValue
);

    // Data is taken on the rising bus clock edge only
    always_ff @(posedge sclClk or negedge rst_n) begin
        if (!rst_n) begin
            bitToggle <= 1'b0;
            bitValue <= 1'b0;
        end else begin
            bitToggle <= ~bitToggle;
            bitValue <= sdaIn;
        end
    end

endmodule

`default_nettype wire

// >>> inc/acsp_map.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 200 MHz system clock, 32-bit registers addressed by byte
// Notes:   Definitions only, no logic
`ifndef ACSP_MAP_SVH
`define ACSP_MAP_SVH

// Register offsets carried in the internal address byte
`define ACSP_OFF_RUN 8'h00
`define ACSP_OFF_FMT 8'h04
`define ACSP_OFF_SLOT 8'h08
`define ACSP_OFF_STEP 8'h04

// Reset values and writable-bit masks; reserved bits read as zero
`define ACSP_RST_RUN 32'h0120_0306
`define ACSP_MSK_RUN 32'hffff_0f3f
`define ACSP_RST_FMT 32'h0028_0028
`define ACSP_MSK_FMT 32'h0f3f_0f3f
`define ACSP_RST_SLOT 32'h0001_0001
`define ACSP_MSK_SLOT 32'hffff_ffff

// Processor run-control fields
`define ACSP_RUN_MODE_LSB 0
`define ACSP_SEND_EN_BIT 2
`define ACSP_IN_FLOAT_BIT 3
`define ACSP_OUT_FLOAT_BIT 5
`define ACSP_MSCL_LSB 8

// Serial-audio format fields
`define ACSP_CHN_LSB 24
`define ACSP_WLEN_LSB 20
`define ACSP_TDM_BIT 19
`define ACSP_FRAME_LSB 16
`define ACSP_RSLOT_LSB 16
`define ACSP_LSLOT_LSB 0

// Slave address base; straps add 0..3
`define ACSP_DEV_BASE 7'h34

// Timing
`define ACSP_CLK_NS 5
`define ACSP_BUS_BIT_NS 2500
`define ACSP_BUS_BIT_CYC (`ACSP_BUS_BIT_NS / `ACSP_CLK_NS)
`define ACSP_MUNIT_NS 166
`define ACSP_MUNIT_MUL (3 * `ACSP_MUNIT_NS)

`endif

// >>> inc/acsp_pkg.sv
// Purpose: Types shared by the control port design
// Assumes: Constants live in acsp_map.svh
// Notes:   One-hot state codes
package acsp_pkg;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_RECV = 5'h02,
        ST_ACK = 5'h04,
        ST_SEND = 5'h08,
        ST_MACK = 5'h10
    } acsp_state_t;

    typedef enum logic [2:0] {
        KD_SEL = 3'h1,
        KD_REG = 3'h2,
        KD_DATA = 3'h4
    } acsp_kind_t;

    typedef enum logic [1:0] {
        RM_BYPASS = 2'h0,
        RM_ZERO = 2'h1,
        RM_ACTIVE = 2'h2
    } acsp_run_t;

endpackage

// >>> tb/acsp_bus_master.sv
// Purpose: Behavioural two-wire bus master for the control port bench
// Assumes: Pull-up on the data wire; quarter bit step of 30 ns
// Notes:   Clock idles high and stands still between frames
`timescale 1ns/1ps
`default_nettype none

module acsp_bus_master (
    output logic sclClk,
    output logic sdaRel,
    input wire logic sdaLine
);
    localparam int Q = 30;

    // Bus idle: both lines released
    initial begin
        sclClk = 1'b1;
        sdaRel = 1'b1;
    end

    // Odd offset keeps link edges off the system clock edges
    task automatic start();
        #3.3;
        sdaRel = 1'b0;
        #Q;
        sclClk = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sdaRel = 1'b0;
        #Q;
        sclClk = 1'b1;
        #Q;
        sdaRel = 1'b1;
        #Q;
    endtask

    // Data moves only while the clock is low; read back mid-high
    task automatic bitIo(input logic b, output logic s);
        sdaRel = b;
        #Q;
        sclClk = 1'b1;
        #Q;
        s = sdaLine;
        #Q;
        sclClk = 1'b0;
        #Q;
    endtask

    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bitIo(d[i], s);
        bitIo(1'b1, ack);
    endtask

    task automatic get(input logic last, output logic [7:0] d);
        logic a;
        for (int i = 7; i >= 0; i--) bitIo(1'b1, d[i]);
        bitIo(last, a);
    endtask
endmodule

`default_nettype wire

// >>> tb/acsp_control_port_checker.sv
// Purpose: Port-level assertions for the two-wire control port
// Assumes: Link pins are sampled in the system clock domain
// Notes:   Bound to the control port from the bench top file
`timescale 1ns/1ps
`default_nettype none

module acsp_control_port_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic [6:0] slaveAddr,
    input wire logic busBusy,
    input wire logic [1:0] runMode,
    input wire logic coefApply,
    input wire logic [3:0] masterSclSel,
    input wire logic [10:0] masterSclPeriodCycles,
    input wire logic [4:0] frameChannelCount,
    input wire logic [5:0] wordBits,
    input wire logic [2:0] frameFormat,
    input wire logic pcmVariantA,
    input wire logic pcmVariantB
);
    // One domain, so clock and reset are given once
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Open drain: the pin is only ever pulled low
    property p_open_drain; sdaOut == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("data pin driven high");
    property p_addr_base; slaveAddr[6:2] == 5'h0d; endproperty
    a_addr_base: assert property (p_addr_base)
        else $error("slave address outside its window");
    // Moving the data pin while the clock is high would fake a start or stop
    property p_oe_scl_low; $changed(sdaOe) |-> !sclClk; endproperty
    a_oe_scl_low: assert property (p_oe_scl_low)
        else $error("data drive changed while bus clock high");
    property p_stop; sclClk && $rose(sdaIn) |-> ##[1:10] !busBusy; endproperty
    a_stop: assert property (p_stop)
        else $error("transfer still busy after stop");
    // Both readings tolerate either latency by waiting for a settled select
    property p_msclk;
        $past(rst_n) && $stable(masterSclSel) ##1 $stable(masterSclSel)
        |-> int'(masterSclPeriodCycles) == (int'(masterSclSel) + 2) * 498 / 5;
    endproperty
    a_msclk: assert property (p_msclk)
        else $error("bus clock period count wrong");
    property p_chan; frameChannelCount != 5'h0 && frameChannelCount <= 5'h10;
    endproperty
    a_chan: assert property (p_chan)
        else $error("channel count out of range");
    property p_variant;
        $stable(frameFormat) |-> frameFormat <= 3'h4 &&
        pcmVariantA == (frameFormat == 3'h3) &&
        pcmVariantB == (frameFormat == 3'h4);
    endproperty
    a_variant: assert property (p_variant)
        else $error("frame format decode wrong");
    property p_word;
        wordBits == 6'h10 || wordBits == 6'h18 || wordBits == 6'h20;
    endproperty
    a_word: assert property (p_word)
        else $error("word length not 16, 24 or 32");
    property p_coef_pulse; coefApply |=> !coefApply; endproperty
    a_coef_pulse: assert property (p_coef_pulse)
        else $error("coefficient update longer than one cycle");
    property p_coef_mode; coefApply |-> ##[0:2] runMode == 2'h2; endproperty
    a_coef_mode: assert property (p_coef_mode)
        else $error("coefficient update without active mode");
endmodule

`default_nettype wire

// >>> tb/acsp_control_port_tb.sv
// Purpose: Self-checking bench for the two-wire control port
// Assumes: Master model on the link; straps and soft reset from here
// Notes:   Outputs are read through the instance after they settle
`timescale 1ns/1ps
`default_nettype none

module acsp_control_port_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic strapLow = 1'b0;
    logic strapHigh = 1'b0;
    logic softReset = 1'b0;
    logic [6:0] devAddr = 7'h34;
    int n_fail = 0;
    int n_checks = 0;
    int nCoef = 0;
    int cyc = 0;
    wire sclClk;
    wire sdaRel;
    wire sdaOut;
    wire sdaOe;
    // Pull-up on the data wire; either party may pull it low
    wire sdaLine = sdaRel & ~sdaOe;

    always #2.5 clk = ~clk;

    acsp_control_port dut (
        .clk(clk), .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .addrStrapLow(strapLow),
        .addrStrapHigh(strapHigh), .softReset(softReset), .slaveAddr(),
        .busBusy(), .runMode(), .coefApply(), .masterSclSel(),
        .masterSclPeriodCycles(), .outFloat(), .inFloat(),
        .serialOutEn(), .frameChannelCount(), .wordBits(), .tdmEnable(),
        .frameFormat(), .pcmVariantA(), .pcmVariantB(),
        .leftSlotEnables(), .rightSlotEnables()
    );
    acsp_bus_master m (.sclClk(sclClk), .sdaRel(sdaRel), .sdaLine(sdaLine));

    task automatic conclude();
        if (n_fail == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Select, offset, then whole words MSB first; nw of 0 only sets offset
    task automatic wr(input logic [7:0] a, input logic [63:0] d,
                      input int nw);
        logic k;
        @(posedge clk);
        m.start();
        m.put({devAddr, 1'b0}, k);
        chk("ack select", 0, k);
        m.put(a, k);
        chk("ack offset", 0, k);
        for (int i = 0; i < nw * 4; i++) begin
            m.put(d[nw * 32 - 1 - 8 * i -: 8], k);
            chk("ack data", 0, k);
        end
        m.stop();
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] g;
        logic k;
        wr(a, 64'h0, 0);
        @(posedge clk);
        m.start();
        m.put({devAddr, 1'b1}, k);
        chk("ack read", 0, k);
        for (int i = 0; i < 4; i++) m.get(i == 3, g[31 - 8 * i -: 8]);
        m.stop();
        chk("read data", e, g);
    endtask

    // Count coefficient-update pulses and cut a hung run short
    always @(posedge clk) begin
        if (dut.coefApply === 1'b1) nCoef++;
        cyc++;
        if (cyc == 80000) begin
            n_fail++;
            conclude();
        end
    end

    initial begin
        static int md[6] = '{1, 2, 0, 2, 3, 2};
        static int cf[6] = '{0, 1, 1, 2, 2, 3};
        static int wb[4] = '{16, 24, 32, 32};
        logic [31:0] v;
        logic k;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        // Reset contents of every register and the derived period
        rd(8'h00, 32'h0120_0306);
        rd(8'h04, 32'h0028_0028);
        rd(8'h08, 32'h0001_0001);
        chk("period", 498, dut.masterSclPeriodCycles);
        chk("formats", 3'h1,
            {dut.outFloat, dut.inFloat, dut.serialOutEn});
        // Mode walk: any change into 10 from another code, the reserved
        // code included, updates coefficients
        for (int i = 0; i < 6; i++) begin
            v = 32'h0000_0f2c | 32'(md[i]);
            wr(8'h00, {32'h0, v}, 1);
            repeat (4) @(posedge clk);
            chk("run mode", md[i], dut.runMode);
            chk("coef count", cf[i], nCoef);
        end
        rd(8'h00, 32'h0000_0f2e);
        chk("period", 1693, dut.masterSclPeriodCycles);
        chk("formats", 3'h7,
            {dut.outFloat, dut.inFloat, dut.serialOutEn});
        wr(8'h00, 64'hffff_ffff, 1);
        rd(8'h00, 32'hffff_0f3f);
        // Every frame code, each word length and even channel counts 2 to 16
        for (int f = 0; f < 8; f++) begin
            v = (32'(2 * f + 1) << 24) | (32'(f % 4) << 20);
            v = v | (32'(f % 2) << 19) | (32'(f) << 16);
            wr(8'h04, {32'h0, v}, 1);
            repeat (4) @(posedge clk);
            chk("channels", 2 * f + 2, dut.frameChannelCount);
            chk("word bits", wb[f % 4], dut.wordBits);
            chk("tdm", f % 2, dut.tdmEnable);
            chk("frame", (f > 3) ? 4 : f, dut.frameFormat);
            chk("variants", {f == 3, f > 3},
                {dut.pcmVariantA, dut.pcmVariantB});
        end
        // Two words in one transfer land at consecutive offsets
        wr(8'h04, 64'h0028_0028_a5a5_5a5a, 2);
        repeat (4) @(posedge clk);
        chk("left slots", 16'h5a5a, dut.leftSlotEnables);
        chk("right slots", 16'ha5a5, dut.rightSlotEnables);
        rd(8'h04, 32'h0028_0028);
        wr(8'h0c, 64'hffff_ffff, 1);
        rd(8'h0c, 32'h0);
        // Neighbouring address must be ignored entirely
        @(posedge clk);
        m.start();
        m.put({7'h35, 1'b0}, k);
        chk("foreign select", 1, k);
        m.put(8'h08, k);
        chk("foreign offset", 1, k);
        m.stop();
        rd(8'h08, 32'ha5a5_5a5a);
        // Straps only count once latched by a soft reset
        for (int s = 3; s >= 0; s--) begin
            @(posedge clk);
            {strapHigh, strapLow} <= 2'(s);
            repeat (8) @(posedge clk);
            chk("addr held", {25'h0, devAddr}, dut.slaveAddr);
            softReset <= 1'b1;
            @(posedge clk);
            softReset <= 1'b0;
            repeat (8) @(posedge clk);
            devAddr = 7'h34 + 7'(s);
            chk("addr", {25'h0, devAddr}, dut.slaveAddr);
            rd(8'h08, 32'ha5a5_5a5a);
        end
        conclude();
    end
endmodule

bind acsp_control_port acsp_control_port_checker u_chk (
    .clk(clk), .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaIn),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .slaveAddr(slaveAddr),
    .busBusy(busBusy), .runMode(runMode), .coefApply(coefApply),
    .masterSclSel(masterSclSel),
    .masterSclPeriodCycles(masterSclPeriodCycles),
    .frameChannelCount(frameChannelCount), .wordBits(wordBits),
    .frameFormat(frameFormat), .pcmVariantA(pcmVariantA),
    .pcmVariantB(pcmVariantB)
);

`default_nettype wire
